// ==== shared/rco_pkg.sv ====
package rco_pkg;
   // register bus geometry
   localparam int          ADDR_W      = 4;
   localparam int          DATA_W      = 32;
   localparam logic [3:0]  OFS_CTRL    = 4'h0;
   localparam logic [3:0]  OFS_SRC     = 4'h4;
   localparam logic [3:0]  OFS_STAT    = 4'h8;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // control register layout
   localparam int          EN_BIT      = 7;
   localparam int          DUTY_HI     = 4;
   localparam int          DUTY_LO     = 3;
   localparam int          DIV_HI      = 2;
   localparam int          DIV_LO      = 0;
   localparam logic [7:0]  CTRL_RST    = 8'h10;
   localparam logic [7:0]  CTRL_WMASK  = 8'h9F;

   // source select register layout
   localparam int          SRC_HI      = 3;
   localparam logic [7:0]  SRC_RST     = 8'h00;
   localparam logic [7:0]  SRC_WMASK   = 8'h0F;
   localparam logic [3:0]  SRC_SYSCLK  = 4'h0;
   localparam logic [3:0]  SRC_LAST    = 4'hA;

   // asynchronous clock sources and divider counter
   localparam int          NUM_ASYNC   = 10;
   localparam int          CNT_W       = 8;

   // generator states, gray coded along idle, arm, run
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARM  = 2'h1,
      ST_RUN  = 2'h3
   } rco_state_t;
endpackage : rco_pkg

// ==== logic/rco_sync.sv ====
`timescale 1ns/1ps
module rco_sync (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [rco_pkg::NUM_ASYNC-1:0] async_in,
   output logic      [rco_pkg::NUM_ASYNC-1:0] synced
);
   import rco_pkg::*;

   typedef struct packed {
      logic [NUM_ASYNC-1:0] meta;
      logic [NUM_ASYNC-1:0] stable;
   } rco_sync_st_t;

   rco_sync_st_t cur_ff;
   rco_sync_st_t nxt_st;

   // two stages; only the second stage is visible outside
   always_comb begin
      nxt_st        = cur_ff;
      nxt_st.meta   = async_in;
      nxt_st.stable = cur_ff.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign synced = cur_ff.stable;
endmodule : rco_sync

// ==== logic/rco_top.sv ====
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Contract
// [RQ1] enabling starts the output cleanly, aligned to a source rising edge
// [RQ2] clearing enable stops driving the output immediately
// [RQ3] software changes divider and duty only while disabled
// [RQ4] divider code n divides the source by two to the power n
// [RQ5] duty codes 11, 10, 01, 00 give 75, 50, 25, 0 percent high
// [RQ6] undivided setting ignores duty and follows the source
// [RQ7] upper duty bit resets to one, default duty 50 percent
// [RQ8] in sleep the output freezes at its current level
// [RQ9] source code picks system clock, oscillators, numeric osc, logic cells
// [RQ10] divider counts edges of the selected source
// [RQ11] control bit 7 enables the module
// [RQ12] unimplemented register bits read as zero
// [RQ13] duty at control bits 4:3, divider 2:0, source at bits 3:0
// [RQ14] duty is the fraction of counts high within each output period
module rco_top (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [rco_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [rco_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [rco_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [rco_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       fast_internal_osc,
   input  wire logic                       slow_internal_osc,
   input  wire logic                       mid_internal_osc_500k,
   input  wire logic                       mid_internal_osc_31k,
   input  wire logic                       secondary_osc,
   input  wire logic                       numeric_osc_output,
   input  wire logic [3:0]                 logic_cell_outputs,
   input  wire logic                       sleep_mode,
   output logic                            refclk_out_pin,
   output logic                            refclk_out_en
);
   import rco_pkg::*;

   typedef struct packed {
      rco_state_t         state;
      logic [7:0]         ctrl;
      logic [7:0]         srcsel;
      logic               tog;
      logic               src_prev;
      logic [CNT_W-1:0]   cnt;
      logic               out;
      logic               out_en;
      logic               aw_held;
      logic [ADDR_W-1:0]  aw_addr;
      logic               w_held;
      logic [7:0]         w_data;
      logic               w_lane0;
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [DATA_W-1:0]  rdata;
      logic [1:0]         rresp;
   } rco_top_st_t;

   rco_top_st_t          cur_ff;
   rco_top_st_t          nxt_st;
   logic [NUM_ASYNC-1:0] async_src;
   logic [NUM_ASYNC-1:0] sync_src;
   logic                 aw_take;
   logic                 w_take;
   logic                 ar_take;
   logic                 wr_fire;
   logic [ADDR_W-1:0]    wr_addr;
   logic [ADDR_W-1:0]    rd_addr;
   logic [7:0]           wr_data;
   logic                 wr_lane0;
   logic                 en_next;
   logic [2:0]           div_sel;
   logic [1:0]           duty_sel;
   logic                 src_lvl;
   logic                 src_edge;
   logic                 src_rise;
   logic [CNT_W-1:0]     cnt_lim;
   logic [CNT_W-1:0]     cnt_thr;
   logic [CNT_W-1:0]     cnt_step;

   // source order matches select codes 1 to 10
   assign async_src = {logic_cell_outputs, numeric_osc_output, secondary_osc,
                       mid_internal_osc_31k, mid_internal_osc_500k,
                       slow_internal_osc, fast_internal_osc};

   rco_sync u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (async_src),
      .synced   (sync_src)
   );

   // bus slave first, then the generator sees the freshly written control register
   always_comb begin
      nxt_st   = cur_ff;
      aw_take  = s_axi_awvalid && cur_ff.awready;
      w_take   = s_axi_wvalid && cur_ff.wready;
      ar_take  = s_axi_arvalid && cur_ff.arready;
      wr_addr  = cur_ff.aw_held ? cur_ff.aw_addr : s_axi_awaddr;
      wr_data  = cur_ff.w_held ? cur_ff.w_data : s_axi_wdata[7:0];
      wr_lane0 = cur_ff.w_held ? cur_ff.w_lane0 : s_axi_wstrb[0];
      wr_fire  = (cur_ff.aw_held || aw_take) && (cur_ff.w_held || w_take) && !cur_ff.bvalid;
      rd_addr  = s_axi_araddr & ~4'h3;

      // address and data may arrive in either order; hold whichever comes first
      if (aw_take) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr & ~4'h3;
      end
      if (w_take) begin
         nxt_st.w_held  = 1'b1;
         nxt_st.w_data  = s_axi_wdata[7:0];
         nxt_st.w_lane0 = s_axi_wstrb[0];
      end
      if (cur_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (wr_fire) begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = RESP_OKAY;
         if ((wr_addr & ~4'h3) == OFS_CTRL) begin
            if (wr_lane0) begin
               nxt_st.ctrl = wr_data & CTRL_WMASK;  // see [RQ11] see [RQ12]
            end
         end else if ((wr_addr & ~4'h3) == OFS_SRC) begin
            if (wr_lane0) begin
               nxt_st.srcsel = wr_data & SRC_WMASK;  // see [RQ12]
            end
         end else if ((wr_addr & ~4'h3) == OFS_STAT) begin
            nxt_st.bresp = RESP_OKAY;  // status is read only, write ignored
         end else begin
            nxt_st.bresp = RESP_SLVERR;
         end
      end
      // one write in flight; address and data stall until the response is taken
      nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
      nxt_st.wready  = !nxt_st.w_held && !nxt_st.bvalid;

      // read path, one outstanding
      if (cur_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (ar_take) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = RESP_OKAY;
         if (rd_addr == OFS_CTRL) begin
            nxt_st.rdata = {24'h000000, cur_ff.ctrl};
         end else if (rd_addr == OFS_SRC) begin
            nxt_st.rdata = {24'h000000, cur_ff.srcsel};
         end else if (rd_addr == OFS_STAT) begin
            nxt_st.rdata = {27'h0000000, sleep_mode, cur_ff.state, cur_ff.out_en,
                            cur_ff.out};
         end else begin
            nxt_st.rdata = 32'h00000000;
            nxt_st.rresp = RESP_SLVERR;
         end
      end
      nxt_st.arready = !nxt_st.rvalid;

      // field extraction from the settings that take effect at this edge
      en_next  = nxt_st.ctrl[EN_BIT];  // see [RQ11]
      duty_sel = nxt_st.ctrl[DUTY_HI:DUTY_LO];  // see [RQ13]
      div_sel  = nxt_st.ctrl[DIV_HI:DIV_LO];  // see [RQ13]

      // source select; the system clock is imaged by a toggle at half rate
      if (cur_ff.srcsel[SRC_HI:0] == SRC_SYSCLK) begin
         src_lvl = cur_ff.tog;  // see [RQ9]
      end else if (cur_ff.srcsel[SRC_HI:0] <= SRC_LAST) begin
         src_lvl = sync_src[cur_ff.srcsel[SRC_HI:0] - 4'h1];  // see [RQ9]
      end else begin
         src_lvl = 1'b0;  // reserved codes give no clock
      end
      src_edge = src_lvl ^ cur_ff.src_prev;  // see [RQ10]
      src_rise = src_lvl & ~cur_ff.src_prev;

      // counting both edges gives 2^(n+1) half periods, so 25 percent fits even at n=1
      cnt_lim  = CNT_W'((16'h0002 << div_sel) - 16'h0001);  // see [RQ4]
      cnt_thr  = CNT_W'({6'h00, duty_sel} << (div_sel - 3'h1));  // see [RQ5] see [RQ14]
      cnt_step = (cur_ff.cnt >= cnt_lim) ? '0 : cur_ff.cnt + 8'h01;

      // generator: disable wins over everything, sleep holds all state
      if (!en_next) begin
         nxt_st.state    = ST_IDLE;
         nxt_st.cnt      = '0;
         nxt_st.out      = 1'b0;  // see [RQ2]
         nxt_st.out_en   = 1'b0;  // see [RQ2]
         nxt_st.tog      = ~cur_ff.tog;
         nxt_st.src_prev = src_lvl;
      end else if (sleep_mode) begin
         nxt_st.state    = cur_ff.state;  // see [RQ8]
      end else begin
         nxt_st.tog      = ~cur_ff.tog;
         nxt_st.src_prev = src_lvl;
         nxt_st.out_en   = 1'b1;
         case (cur_ff.state)
            ST_IDLE: begin
               nxt_st.state = ST_ARM;
               nxt_st.out   = 1'b0;  // see [RQ1]
            end
            ST_ARM: begin
               // wait for a rising edge so the first high phase is full length
               if (src_rise) begin
                  nxt_st.state = ST_RUN;  // see [RQ1]
                  nxt_st.cnt   = '0;
                  nxt_st.out   = (div_sel == 3'h0) ? 1'b1 : (cnt_thr != '0);
               end
            end
            ST_RUN: begin
               if (div_sel == 3'h0) begin
                  nxt_st.out = src_lvl;  // see [RQ6]
               end else if (src_edge) begin
                  nxt_st.cnt = cnt_step;  // see [RQ10]
                  nxt_st.out = cnt_step < cnt_thr;  // see [RQ14] see [RQ5]
               end
            end
            default: begin
               nxt_st.state = ST_IDLE;
               nxt_st.out   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_ff        <= '0;
         cur_ff.state  <= ST_IDLE;
         cur_ff.ctrl   <= CTRL_RST;  // see [RQ7]
         cur_ff.srcsel <= SRC_RST;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // every output straight from the state register
   assign s_axi_awready  = cur_ff.awready;
   assign s_axi_wready   = cur_ff.wready;
   assign s_axi_bvalid   = cur_ff.bvalid;
   assign s_axi_bresp    = cur_ff.bresp;
   assign s_axi_arready  = cur_ff.arready;
   assign s_axi_rvalid   = cur_ff.rvalid;
   assign s_axi_rdata    = cur_ff.rdata;
   assign s_axi_rresp    = cur_ff.rresp;
   assign refclk_out_pin = cur_ff.out;
   assign refclk_out_en  = cur_ff.out_en;

   // checks on the generator and the register file
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_enable_rise;
      !cur_ff.ctrl[EN_BIT] ##1 cur_ff.ctrl[EN_BIT];
   endsequence

   sequence s_sleep_run;
      sleep_mode && cur_ff.ctrl[EN_BIT] && en_next;
   endsequence

   sequence s_wrap_edge;
      cur_ff.state == ST_RUN && src_edge && cur_ff.cnt == cnt_lim && div_sel != 3'h0
         && en_next && !sleep_mode && $stable(cur_ff.ctrl);
   endsequence

   a_start_clean: assert property (  // see [RQ1]
      s_enable_rise |-> !refclk_out_pin && cur_ff.state == ST_ARM)
      else $error("output not held low while arming");

   a_arm_hold_low: assert property (  // see [RQ1]
      cur_ff.state == ST_ARM && !src_rise && en_next && !sleep_mode |=> !refclk_out_pin)
      else $error("output rose before a source rising edge");

   a_disable_stop: assert property (  // see [RQ2]
      !cur_ff.ctrl[EN_BIT] |-> !refclk_out_pin && !refclk_out_en)
      else $error("output still driven while disabled");

   a_period_wrap: assert property (  // see [RQ4]
      s_wrap_edge |=> cur_ff.cnt == '0 && refclk_out_pin == ($past(duty_sel) != 2'h0))
      else $error("divided period did not restart at the count limit");

   a_duty_zero_low: assert property (  // see [RQ5]
      cur_ff.state == ST_RUN && div_sel != 3'h0 && duty_sel == 2'h0
         && $stable(cur_ff.ctrl) && $past(cur_ff.state) == ST_RUN |-> !refclk_out_pin)
      else $error("zero duty drove the output high");

   a_duty_fall: assert property (  // see [RQ14]
      cur_ff.state == ST_RUN && div_sel != 3'h0 && src_edge && cnt_step == cnt_thr
         && en_next && !sleep_mode |=> !refclk_out_pin)
      else $error("output did not fall at the duty threshold");

   a_undiv_follow: assert property (  // see [RQ6]
      cur_ff.state == ST_RUN && div_sel == 3'h0 && en_next && !sleep_mode
         |=> refclk_out_pin == $past(src_lvl))
      else $error("undivided output does not follow the source");

   // reset itself is the antecedent, so the default disable must not apply here
   a_reset_duty: assert property (  // see [RQ7]
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> cur_ff.ctrl == CTRL_RST && cur_ff.srcsel == SRC_RST)
      else $error("control register reset value wrong");

   a_sleep_freeze: assert property (  // see [RQ8]
      s_sleep_run |=> $stable(refclk_out_pin) && $stable(cur_ff.cnt))
      else $error("output moved during sleep");

   a_source_pick: assert property (  // see [RQ9]
      (cur_ff.srcsel[SRC_HI:0] > SRC_LAST |-> !src_lvl)
      and (cur_ff.srcsel[SRC_HI:0] == SRC_SYSCLK |-> src_lvl == cur_ff.tog))
      else $error("source selection wrong");

   a_count_edges: assert property (  // see [RQ10]
      cur_ff.state == ST_RUN && !src_edge && en_next |=> $stable(cur_ff.cnt))
      else $error("counter moved without a source edge");

   a_enable_write: assert property (  // see [RQ11]
      wr_fire && wr_addr == OFS_CTRL && wr_lane0 |=> cur_ff.ctrl[EN_BIT] == $past(wr_data[7]))
      else $error("enable bit not taken from write data bit 7");

   a_reserved_zero: assert property (  // see [RQ12]
      s_axi_rvalid |-> s_axi_rdata[31:8] == '0 && cur_ff.ctrl[6:5] == 2'h0
         && cur_ff.srcsel[7:4] == 4'h0)
      else $error("unimplemented bits not zero");

   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before it was taken");
endmodule : rco_top

// ==== dv/rco_osc_model.sv ====
`timescale 1ns/1ps
// free-running source oscillators; source n toggles every n+1 bench cycles
// the 10 ns offset keeps every toggle away from the bench clock edges, so the
// synchroniser sees each edge at a fixed cycle and periods measure exactly
module rco_osc_model (
   output logic [9:0] osc
);
   // one oscillator per selectable source, codes 1 to 10 in order
   for (genvar i = 0; i < 10; i++) begin : g_osc
      logic lvl;
      initial begin
         lvl = 1'b0;
         #10;
         forever #(50 * (i + 2)) lvl = ~lvl;
      end
      assign osc[i] = lvl;
   end
endmodule : rco_osc_model

// ==== dv/test_reference_clock_output.sv ====
`timescale 1ns/1ps
module test_reference_clock_output;
   import rco_pkg::*;
   logic              aclk, aresetn, sleep_mode, p;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, v;
   logic [3:0]        wstrb;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, pin, pin_en, pin_q, seen;
   logic [1:0]        bresp, rresp;
   logic [9:0]        osc;
   logic [63:0]       e;
   logic [1:0]        wq[$];
   logic [33:0]       rq[$];
   logic [63:0]       cq[$];
   int                error_cnt, checked, cycles, hi_cnt, per_cnt;

   rco_top u_rco_top (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fast_internal_osc(osc[0]), .slow_internal_osc(osc[1]),
      .mid_internal_osc_500k(osc[2]), .mid_internal_osc_31k(osc[3]),
      .secondary_osc(osc[4]), .numeric_osc_output(osc[5]),
      .logic_cell_outputs(osc[9:6]), .sleep_mode(sleep_mode),
      .refclk_out_pin(pin), .refclk_out_en(pin_en)
   );

   rco_osc_model u_rco_osc_model (
      .osc(osc)
   );

   // bench clock, 50 ns period
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // one idle edge on entry so a strobe is never reassigned in one time step
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] r);
      @(posedge aclk);
      wq.push_back(r);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      rq.push_back({r, d});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
   endtask : axi_rd

   // source half period is src+1 cycles (system clock imaged at aclk/2)
   task automatic run_clk(input logic [3:0] src, input logic [2:0] dv, input logic [1:0] dc);
      int h, hi, per;
      h   = int'(src) + 1;
      per = h << (dv + 1);
      hi  = (dv == 3'h0) ? h : ((int'(dc) * h) << (dv - 3'h1));
      axi_wr(OFS_SRC, 32'(src), 4'h1, RESP_OKAY);
      axi_wr(OFS_CTRL, {24'h0, 1'b1, 2'b00, dc, dv}, 4'h1, RESP_OKAY);
      if (hi == 0) begin
         repeat (3 * per) @(posedge aclk);
         cmp(64'(pin), 64'h0);
      end else begin
         repeat (2) cq.push_back({32'(hi), 32'(per)});
         repeat (3 * per + 4 * h + 8) @(posedge aclk);
         cmp(64'(cq.size()), 64'h0);
         // disable in mid high phase: the pin must not finish the period
         while (!pin) @(posedge aclk);
      end
      axi_wr(OFS_CTRL, 32'h0, 4'h1, RESP_OKAY);
      cmp({62'h0, pin, pin_en}, 64'h0);
   endtask : run_clk

   // result watcher: bus answers and pin periods against the oldest notes
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 60000) begin
         error_cnt++;
         final_report();
      end
      if (bvalid && bready) cmp(64'(bresp), 64'(wq.pop_front()));
      if (rvalid && rready) cmp({30'h0, rresp, rdata}, 64'(rq.pop_front()));
      if (!pin_en) begin
         seen = 1'b0;
      end else if (pin && !pin_q) begin
         if (seen && cq.size() > 0) begin
            e = cq.pop_front();
            cmp(64'(hi_cnt), {32'h0, e[63:32]});
            cmp(64'(per_cnt), {32'h0, e[31:0]});
         end
         seen    = 1'b1;
         hi_cnt  = 0;
         per_cnt = 0;
      end
      per_cnt++;
      if (pin) hi_cnt++;
      pin_q = pin;
   end

   initial begin
      {aresetn, sleep_mode, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {error_cnt, checked, cycles, hi_cnt, per_cnt} = '0;
      {pin_q, seen} = 2'h0;
      v = $urandom(32'h37B6);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_rd(OFS_CTRL, 32'h10, RESP_OKAY);
      axi_rd(OFS_SRC, 32'h0, RESP_OKAY);
      axi_rd(OFS_STAT, 32'h0, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         v = $urandom & 32'hFFFFFF7F;
         axi_wr(OFS_CTRL, v, 4'hF, RESP_OKAY);
         axi_rd(OFS_CTRL, v & 32'h9F, RESP_OKAY);
         v = $urandom;
         axi_wr(OFS_SRC, v, 4'hF, RESP_OKAY);
         axi_rd(OFS_SRC, v & 32'hF, RESP_OKAY);
      end
      axi_wr(OFS_CTRL, 32'h0B, 4'hF, RESP_OKAY);
      axi_wr(OFS_CTRL, 32'h15, 4'h0, RESP_OKAY);
      axi_rd(OFS_CTRL, 32'h0B, RESP_OKAY);
      axi_wr(OFS_STAT, 32'hFF, 4'hF, RESP_OKAY);
      axi_wr(4'hC, 32'h1, 4'hF, RESP_SLVERR);
      axi_rd(4'hC, 32'h0, RESP_SLVERR);
      axi_rd(OFS_STAT, 32'h0, RESP_OKAY);
      // every divider code; undivided with duty 00 must still follow the source
      for (int d = 0; d < 8; d++) begin
         run_clk(4'h0, 3'(d), (d == 0) ? 2'h0 : 2'(1 + d % 3));
      end
      for (int d = 0; d < 4; d++) run_clk(4'h0, 3'h2, 2'(d));
      for (int s = 1; s < 11; s++) begin
         run_clk(4'(s), 3'($urandom % 3), 2'(1 + $urandom % 3));
      end
      // reserved sources give no edges: enabled but low
      for (int s = 11; s < 16; s++) begin
         axi_wr(OFS_SRC, 32'(s), 4'h1, RESP_OKAY);
         axi_wr(OFS_CTRL, 32'h91, 4'h1, RESP_OKAY);
         repeat (20) @(posedge aclk);
         cmp({62'h0, pin, pin_en}, 64'h1);
         axi_wr(OFS_CTRL, 32'h0, 4'h1, RESP_OKAY);
      end
      // sleep while running: pin holds its level for longer than a period
      axi_wr(OFS_SRC, 32'h0, 4'h1, RESP_OKAY);
      axi_wr(OFS_CTRL, 32'h92, 4'h1, RESP_OKAY);
      repeat (17) @(posedge aclk);
      sleep_mode <= 1'b1;
      repeat (2) @(posedge aclk);
      p = pin;
      repeat (12) begin
         @(posedge aclk);
         cmp(64'(pin), 64'(p));
      end
      // status while frozen: sleep flag, running state, driven, frozen level
      axi_rd(OFS_STAT, 32'h1E | 32'(p), RESP_OKAY);
      sleep_mode <= 1'b0;
      axi_wr(OFS_CTRL, 32'h0, 4'h1, RESP_OKAY);
      final_report();
   end
endmodule : test_reference_clock_output
